// *** hdl/spi_crc_pkg.sv ***
// constants, state type and checksum function for the serial slave port
package spi_crc_pkg;
  localparam int DATA_W = 14;
  localparam int ADDR_W = 14;
  localparam int RX_W   = 32;
  localparam int TX_W   = 24;
  localparam int CNT_W  = 6;

  localparam int SYS_CLK_HZ  = 10000000;
  localparam int SCLK_MAX_HZ = 10000000;

  // frame lengths in received bits
  localparam logic [CNT_W-1:0] LEN_SHORT = 6'h10;
  localparam logic [CNT_W-1:0] LEN_CRC   = 6'h18;
  localparam logic [CNT_W-1:0] LEN_MAX   = 6'h3F;

  // field positions in the lowest 24 received bits
  localparam int SHORT_RD_BIT = 14;
  localparam int RW_BIT       = 22;
  localparam int PAY_MSB      = 23;
  localparam int PAY_LSB      = 8;
  localparam int FLD_MSB      = 21;
  localparam int CRC_MSB      = 7;

  // error flag register
  localparam logic [ADDR_W-1:0] ERR_ADDR  = 14'h0001;
  localparam logic [DATA_W-1:0] ERR_RESET = 14'h0000;
  localparam int ERR_CRC_BIT = 6;
  localparam int ERR_CMD_BIT = 5;
  localparam int ERR_FRM_BIT = 4;

  // checksum
  localparam logic [7:0] CRC_POLY   = 8'h1D;
  localparam logic [7:0] CRC_INIT   = 8'hFF;
  localparam logic [7:0] CRC_XOROUT = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR   = 3'b001,
    ST_RD   = 3'b011,
    ST_WT   = 3'b010,
    ST_LD   = 3'b110
  } seq_state_t;

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    logic       fb;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c ^ CRC_XOROUT;
  endfunction
endpackage

// *** hdl/angle_sensor_spi_slave_crc.sv ***
// serial slave port with checksum, pipelined responses and error flag register
// Summary of operation
// - device is slave only; host clocks the link at 10 MHz or less
// - mode CPOL 0, CPHA 1; frame starts when select falls, clock low
// - each MOSI bit is captured on the falling clock edge
// - commands execute only at the rising select edge ending the frame
// - all fields shift most significant bit first both ways
// - 16-bit frame: no checksum, read only, bit 14 set, address 13:0
// - response: warning bit, error bit, 14 data bits from previous frame
// - 24-bit frame: direction bit 22, address 21:8, checksum 7:0
// - 32-bit frame adds an 8-bit pad field ahead of the 24 bits
// - checksum mismatch sets the communication fault flag
// - read data latched at frame end, sent in the following frame
// - data frame returns old content; next frame returns updated content
// - up to four 8-bit pad groups may precede the payload
// - checksum covers payload bits 23:8 only
// - checksum polynomial x^8+x^4+x^3+x^2+1
// - checksum preset to 0xFF for every frame
// - an all-zero frame is rejected by the preset checksum
// - responses in frames of 24 bits or more carry the device's own checksum
// - fault flags: checksum bit 6, bad command bit 5, framing bit 4
// - reading the error flag register clears it
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module angle_sensor_spi_slave_crc (
  // clock, reset, enable
  input  wire  logic                            sys_clk,
  input  wire  logic                            sys_rst,
  input  wire  logic                            clk_en,
  // serial link
  input  wire  logic                            sclk,
  input  wire  logic                            select_low,
  input  wire  logic                            mosi,
  output logic                                  miso,
  output logic                                  miso_oe_n,
  // register file access
  output logic [spi_crc_pkg::ADDR_W-1:0]        reg_addr,
  output logic [spi_crc_pkg::DATA_W-1:0]        reg_wdata,
  output logic                                  reg_wr,
  output logic                                  reg_rd,
  input  wire  logic [spi_crc_pkg::DATA_W-1:0]  reg_rdata,
  // status
  input  wire  logic                            warn_in,
  input  wire  logic [spi_crc_pkg::DATA_W-1:0]  fault_set,
  output logic [spi_crc_pkg::DATA_W-1:0]        error_flag_register
);
  import spi_crc_pkg::*;

  logic [2:0]        sclk_q;
  logic [2:0]        sel_q;
  logic [1:0]        mosi_q;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              sel_act;
  logic              frame_start;
  logic              frame_end;
  logic [RX_W-1:0]   rx_sh;
  logic [CNT_W-1:0]  bit_cnt;
  logic [TX_W-1:0]   tx_sh;
  seq_state_t        state_reg;
  logic              len_short;
  logic              len_crc;
  logic              frame_bad;
  logic              crc_bad;
  logic              cmd_bad;
  logic              cmd_ok;
  logic              data_frame;
  logic              dec_read;
  logic [ADDR_W-1:0] dec_addr;
  logic              wr_pending;
  logic [ADDR_W-1:0] wr_addr;
  logic              op_wr;
  logic              op_rd;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata;
  logic              warn_q;
  logic              fault_q;
  logic              is_int;
  logic [DATA_W-1:0] int_data;
  logic              err_clr;
  logic [DATA_W-1:0] err_set;
  logic [DATA_W-1:0] resp_data;
  logic [15:0]       resp_hdr;

  // link synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sclk_q <= 3'h0;
      sel_q  <= 3'h7;
      mosi_q <= 2'h0;
    end else if (clk_en) begin
      sclk_q <= {sclk_q[1:0], sclk};
      sel_q  <= {sel_q[1:0], select_low};
      mosi_q <= {mosi_q[0], mosi};
    end
  end

  assign sclk_rise   = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall   = ~sclk_q[1] & sclk_q[2];
  assign sel_act     = ~sel_q[1];
  assign frame_start = ~sel_q[1] & sel_q[2];
  assign frame_end   = sel_q[1] & ~sel_q[2];

  // receive shifter and edge counter
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_sh   <= '0;
      bit_cnt <= '0;
    end else if (clk_en) begin
      if (frame_start) begin
        bit_cnt <= '0;
      end else if (sel_act && sclk_fall) begin
        rx_sh <= {rx_sh[RX_W-2:0], mosi_q[1]};
        if (bit_cnt != LEN_MAX) begin
          bit_cnt <= bit_cnt + 6'h01;
        end
      end
    end
  end

  // frame decode, valid in the frame_end cycle
  always_comb begin
    len_short = (bit_cnt == LEN_SHORT);
    len_crc   = (bit_cnt >= LEN_CRC) && (bit_cnt[2:0] == 3'h0);
    frame_bad = !(len_short || len_crc);
    crc_bad   = len_crc &&
                (crc8(rx_sh[PAY_MSB:PAY_LSB]) != rx_sh[CRC_MSB:0]);
    dec_read  = len_short ? rx_sh[SHORT_RD_BIT] : rx_sh[RW_BIT];
    dec_addr  = len_short ? rx_sh[ADDR_W-1:0] : rx_sh[FLD_MSB:PAY_LSB];
    cmd_bad   = !frame_bad && !crc_bad && len_short &&
                (!rx_sh[SHORT_RD_BIT] || wr_pending);
    cmd_ok    = !frame_bad && !crc_bad && !cmd_bad && !wr_pending;
    data_frame = wr_pending && len_crc && !crc_bad;
  end

  // latch the action of a finished frame
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op_wr      <= 1'b0;
      op_rd      <= 1'b0;
      acc_addr   <= '0;
      acc_wdata  <= '0;
      warn_q     <= 1'b0;
      fault_q    <= 1'b0;
      wr_pending <= 1'b0;
      wr_addr    <= '0;
    end else if (clk_en && frame_end) begin
      op_wr      <= data_frame;
      op_rd      <= data_frame || cmd_ok;
      acc_addr   <= data_frame ? wr_addr : dec_addr;
      acc_wdata  <= rx_sh[FLD_MSB:PAY_LSB];
      warn_q     <= warn_in;
      fault_q    <= frame_bad || crc_bad || cmd_bad;
      wr_pending <= cmd_ok && !dec_read;
      if (cmd_ok && !dec_read) begin
        wr_addr <= dec_addr;
      end
    end
  end

  assign is_int = (acc_addr == ERR_ADDR);

  // execution sequence after frame end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        ST_IDLE: begin
          if (frame_end) begin
            state_reg <= ST_WR;
          end
        end
        ST_WR:   state_reg <= ST_RD;
        ST_RD:   state_reg <= ST_WT;
        ST_WT:   state_reg <= ST_LD;
        ST_LD:   state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // register file strobes; the error register is served locally
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_addr  <= '0;
      reg_wdata <= '0;
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
    end else if (clk_en) begin
      reg_wr <= (state_reg == ST_WR) && op_wr && !is_int;
      reg_rd <= (state_reg == ST_RD) && op_rd && !is_int;
      if (state_reg == ST_WR) begin
        reg_addr  <= acc_addr;
        reg_wdata <= acc_wdata;
      end
    end
  end

  assign err_clr = (state_reg == ST_RD) && op_rd && is_int;

  always_comb begin
    err_set = fault_set;
    if (frame_end) begin
      err_set[ERR_CRC_BIT] = crc_bad;
      err_set[ERR_CMD_BIT] = cmd_bad;
      err_set[ERR_FRM_BIT] = frame_bad;
      err_set = err_set | fault_set;
    end
  end

  // sticky flags; a set in the clearing cycle survives
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      error_flag_register <= ERR_RESET;
      int_data            <= '0;
    end else if (clk_en) begin
      if (err_clr) begin
        int_data <= error_flag_register;
      end
      error_flag_register <= (err_clr ? ERR_RESET : error_flag_register) | err_set;
    end
  end

  always_comb begin
    resp_data = '0;
    if (op_rd) begin
      resp_data = is_int ? int_data : reg_rdata;
    end
    resp_hdr = {warn_q, fault_q, resp_data};
  end

  // transmit shifter, updated on rising link clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_sh     <= '0;
      miso      <= 1'b0;
      miso_oe_n <= 1'b1;
    end else if (clk_en) begin
      miso_oe_n <= ~sel_act;
      if (state_reg == ST_LD) begin
        tx_sh <= {resp_hdr, crc8(resp_hdr)};
      end else if (sel_act && sclk_rise) begin
        miso  <= tx_sh[TX_W-1];
        tx_sh <= {tx_sh[TX_W-2:0], 1'b0};
      end
    end
  end

  // checks
  sequence s_write_exec;
    ##2 reg_wr ##1 reg_rd;
  endsequence

  sequence s_read_issue;
    ##3 reg_rd;
  endsequence

  property p_oe_idle;
    @(posedge sys_clk) disable iff (sys_rst)
      select_low [*4] |=> miso_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("miso driven while idle");

  property p_capture;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && sel_act && sclk_fall && !frame_start && bit_cnt < LEN_MAX |=>
        bit_cnt == $past(bit_cnt) + 6'h01 && rx_sh[0] == $past(mosi_q[1]);
  endproperty
  a_capture: assert property (p_capture) else $error("bit not captured on fall");

  property p_end_only;
    @(posedge sys_clk) disable iff (sys_rst)
      reg_wr |-> $past(frame_end, 2);
  endproperty
  a_end_only: assert property (p_end_only) else $error("write outside frame end");

  property p_msb_out;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && sel_act && sclk_rise && state_reg != ST_LD |=> miso == $past(tx_sh[TX_W-1]);
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("miso not msb first");

  property p_resp_crc;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_reg == ST_LD |=>
        tx_sh[7:0] == crc8(tx_sh[23:8]) && tx_sh[22] == $past(fault_q);
  endproperty
  a_resp_crc: assert property (p_resp_crc) else $error("response checksum wrong");

  property p_crc_flag;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && frame_end && crc_bad |=> error_flag_register[ERR_CRC_BIT];
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("checksum fault not flagged");

  property p_zero_frame;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && frame_end && len_crc && rx_sh[23:0] == 24'h00_0000 |->
        ##1 error_flag_register[ERR_CRC_BIT] ##0 (!reg_wr && !reg_rd) [*4];
  endproperty
  a_zero_frame: assert property (p_zero_frame) else $error("zero frame accepted");

  property p_frm_flag;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && frame_end && frame_bad |=> error_flag_register[ERR_FRM_BIT] && !op_rd;
  endproperty
  a_frm_flag: assert property (p_frm_flag) else $error("framing fault not flagged");

  property p_cmd_flag;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && frame_end && cmd_bad |=> error_flag_register[ERR_CMD_BIT];
  endproperty
  a_cmd_flag: assert property (p_cmd_flag) else $error("bad command not flagged");

  property p_err_clear;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && err_clr && fault_set == ERR_RESET |=> error_flag_register == ERR_RESET;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error register not cleared");

  property p_read_issue;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && frame_end && cmd_ok && dec_read && dec_addr != ERR_ADDR |->
        s_read_issue ##0 reg_addr == $past(dec_addr, 3);
  endproperty
  a_read_issue: assert property (p_read_issue) else $error("read not issued");

  property p_write_exec;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && frame_end && data_frame && wr_addr != ERR_ADDR |-> s_write_exec;
  endproperty
  a_write_exec: assert property (p_write_exec) else $error("write then readback missing");

  property p_warn_latch;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && frame_end |=>
        warn_q == $past(warn_in) && fault_q == ($past(frame_bad) || $past(crc_bad) || $past(cmd_bad));
  endproperty
  a_warn_latch: assert property (p_warn_latch) else $error("flags of the last frame not kept");

  property p_resp_load;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_reg == ST_LD && op_rd && !is_int |=> tx_sh[21:8] == $past(reg_rdata);
  endproperty
  a_resp_load: assert property (p_resp_load) else $error("read data not loaded for reply");

  property p_err_snap;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && err_clr |=> int_data == $past(error_flag_register);
  endproperty
  a_err_snap: assert property (p_err_snap) else $error("error register not captured on read");

  property p_act_at_end;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && !frame_end |=> $stable(op_wr) && $stable(op_rd) && $stable(acc_addr);
  endproperty
  a_act_at_end: assert property (p_act_at_end) else $error("action changed inside a frame");

  property p_fault_drops_write;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && frame_end && (frame_bad || crc_bad || cmd_bad) |=> !wr_pending && !op_wr;
  endproperty
  a_fault_drops_write: assert property (p_fault_drops_write) else $error("pending write kept after fault");

  property p_miso_quiet;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && !sel_act |=> $stable(miso);
  endproperty
  a_miso_quiet: assert property (p_miso_quiet) else $error("miso moved outside a frame");

  property p_err_ro;
    @(posedge sys_clk) disable iff (sys_rst)
      reg_wr |-> reg_addr != ERR_ADDR;
  endproperty
  a_err_ro: assert property (p_err_ro) else $error("write reached the error register");
endmodule

// *** tb/spi_host_model.sv ***
// behavioural host that clocks frames into the serial port
`timescale 1ns/1ns
module spi_host_model (
  // clock
  input  wire logic        sys_clk,
  // serial link
  output logic             sclk,
  output logic             select_low,
  output logic             mosi,
  input  wire logic        miso,
  input  wire logic        miso_oe_n,
  // received response
  output logic [31:0]      rx_word,
  output logic             rx_done
);
  logic miso_last = 1'b0;
  wire  miso_line = !miso_oe_n ? miso : ~miso_last;

  initial begin
    sclk       = 1'b0;
    select_low = 1'b1;
    mosi       = 1'b0;
    rx_word    = 32'h0000_0000;
    rx_done    = 1'b0;
  end

  // released line shows the inverse of its last driven level
  always @(posedge sys_clk) begin
    if (!miso_oe_n) begin
      miso_last <= miso;
    end
  end

  // half period of four system cycles gives an 800 ns link clock
  task automatic xfer(input int n, input logic [31:0] w);
    logic [31:0] r;
    r = 32'h0000_0000;
    @(posedge sys_clk);
    select_low <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'b1;
      mosi <= w[i];
      repeat (4) @(posedge sys_clk);
      sclk <= 1'b0;
      r = {r[30:0], miso_line};
      repeat (4) @(posedge sys_clk);
    end
    select_low <= 1'b1;
    mosi       <= ~w[0];
    rx_word    <= r;
    rx_done    <= 1'b1;
    @(posedge sys_clk);
    rx_done <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule

// *** tb/angle_sensor_spi_slave_crc_test.sv ***
// self-checking bench for the serial slave port
`timescale 1ns/1ns
module angle_sensor_spi_slave_crc_test;
  import spi_crc_pkg::*;

  logic                sys_clk;
  logic                sys_rst;
  logic                clk_en;
  logic                sclk;
  logic                select_low;
  logic                mosi;
  logic                miso;
  logic                miso_oe_n;
  logic [ADDR_W-1:0]   reg_addr;
  logic [DATA_W-1:0]   reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [DATA_W-1:0]   reg_rdata;
  logic                warn_in;
  logic [DATA_W-1:0]   fault_set;
  logic [DATA_W-1:0]   error_flag_register;
  logic [31:0]         rx_word;
  logic                rx_done;
  logic [DATA_W-1:0]   mem [0:15];
  logic [DATA_W-1:0]   shadow [0:15];
  logic [31:0]         exp_q [$];
  logic [23:0]         nxt;
  logic [DATA_W-1:0]   nv;
  logic [31:0]         rnd;
  integer              seed;
  int                  mismatches;
  int                  tests_run;

  angle_sensor_spi_slave_crc i_dut (
    .sys_clk             (sys_clk),
    .sys_rst             (sys_rst),
    .clk_en              (clk_en),
    .sclk                (sclk),
    .select_low          (select_low),
    .mosi                (mosi),
    .miso                (miso),
    .miso_oe_n           (miso_oe_n),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .warn_in             (warn_in),
    .fault_set           (fault_set),
    .error_flag_register (error_flag_register)
  );

  spi_host_model i_host (
    .sys_clk    (sys_clk),
    .sclk       (sclk),
    .select_low (select_low),
    .mosi       (mosi),
    .miso       (miso),
    .miso_oe_n  (miso_oe_n),
    .rx_word    (rx_word),
    .rx_done    (rx_done)
  );

  always #50 sys_clk = ~sys_clk;

  // register file behind the port, read data valid the cycle after the strobe
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 14'h0000;
      for (int i = 0; i < 16; i++) begin
        mem[i] <= shadow[i];
      end
    end else begin
      if (reg_rd) begin
        reg_rdata <= mem[reg_addr[3:0]];
      end
      if (reg_wr) begin
        mem[reg_addr[3:0]] <= reg_wdata;
      end
    end
  end

  function automatic logic [7:0] crc(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ d[i]) == 1'b1) ? CRC_POLY : 8'h00);
    end
    return c ^ CRC_XOROUT;
  endfunction

  function automatic logic [23:0] mk(input logic [15:0] p, input logic bad);
    return {p, crc(p) ^ {7'h00, bad}};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sends one frame; notes what it must return and what the next frame returns
  task automatic frame(input int n, input logic [31:0] w, input logic [13:0] d, input logic e);
    logic [31:0] r;
    logic        wv;
    r  = $random(seed);
    wv = r[0];
    warn_in <= wv;
    exp_q.push_back({nxt, 8'h00} >> (32 - n));
    i_host.xfer(n, w);
    nxt = {wv, e, d, crc({wv, e, d})};
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // responses are judged in arrival order
  always @(posedge sys_clk) begin
    if (rx_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(rx_word, 32'hFFFF_FFFF);
      end else begin
        check(rx_word, exp_q.pop_front());
      end
    end
  end

  initial begin
    #2_000_000;
    mismatches++;
    stop_test;
  end

  initial begin
    sys_clk    = 1'b0;
    sys_rst    = 1'b1;
    warn_in    = 1'b0;
    fault_set  = 14'h0000;
    clk_en     = 1'b1;
    seed       = 32'h1af8_fb6d;
    mismatches = 0;
    tests_run  = 0;
    nxt        = 24'h00_0000;
    for (int i = 0; i < 16; i++) begin
      rnd       = $random(seed);
      shadow[i] = rnd[DATA_W-1:0];
    end
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    frame(24, {8'h00, mk({2'b01, 14'h0005}, 1'b0)}, shadow[5], 1'b0);
    frame(16, {16'h0000, 2'b01, 14'h0006}, shadow[6], 1'b0);
    frame(32, {8'hA5, mk({2'b01, 14'h0007}, 1'b0)}, shadow[7], 1'b0);
    frame(24, {8'h00, mk({2'b00, 14'h0003}, 1'b0)}, shadow[3], 1'b0);
    rnd = $random(seed);
    nv  = rnd[DATA_W-1:0];
    shadow[3] = nv;
    frame(24, {8'h00, mk({2'b00, nv}, 1'b0)}, nv, 1'b0);
    frame(24, {8'h00, mk({2'b01, 14'h0005}, 1'b1)}, 14'h0000, 1'b1);
    frame(20, 32'h0004_0005, 14'h0000, 1'b1);
    frame(16, {16'h0000, 2'b00, 14'h0005}, 14'h0000, 1'b1);
    frame(24, 32'h0000_0000, 14'h0000, 1'b1);
    @(posedge sys_clk);
    clk_en    <= 1'b0;
    fault_set <= 14'h0008;
    @(posedge sys_clk);
    clk_en    <= 1'b1;
    fault_set <= 14'h0001;
    @(posedge sys_clk);
    fault_set <= 14'h0000;
    @(posedge sys_clk);
    check({18'h0_0000, error_flag_register}, 32'h0000_0071);
    frame(24, {8'h00, mk({2'b01, ERR_ADDR}, 1'b0)}, 14'h0071, 1'b0);
    check({18'h0_0000, error_flag_register}, 32'h0000_0000);
    frame(24, {8'h00, mk({2'b01, 14'h0003}, 1'b0)}, shadow[3], 1'b0);
    frame(16, {16'h0000, 2'b01, 14'h0005}, shadow[5], 1'b0);
    frame(24, {8'h00, mk({2'b00, 14'h0004}, 1'b0)}, shadow[4], 1'b0);
    frame(16, {16'h0000, 2'b01, 14'h0005}, 14'h0000, 1'b1);
    frame(16, {16'h0000, 2'b01, 14'h0004}, shadow[4], 1'b0);
    frame(16, {16'h0000, 2'b01, 14'h0005}, shadow[5], 1'b0);
    stop_test;
  end
endmodule
